// *** hdl/tpl_pkg.sv ***
package tpl_pkg;

  // register byte offsets
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_SEL      = 8'h04;
  localparam logic [7:0]  ADDR_SRC      = 8'h08;
  localparam logic [7:0]  ADDR_DST      = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS   = 8'h10;
  localparam logic [7:0]  ADDR_RESULT   = 8'h14;
  localparam logic [7:0]  ADDR_INT_STAT = 8'h18;
  localparam logic [7:0]  ADDR_INT_MASK = 8'h1C;

  // control word bits
  localparam int CTRL_EXEC_BIT = 0;
  localparam int CTRL_ADDR_BIT = 1;
  localparam int CTRL_RUN_BIT  = 2;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // status and interrupt bits
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_ERR_BIT   = 1;
  localparam int ST_ZERO_BIT  = 2;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_ERR_BIT  = 1;
  localparam logic [1:0] INT_RESET = 2'h0;

  // selector constants and trig limit
  localparam logic [15:0] SEL_SINE     = 16'h0000;
  localparam logic [15:0] SEL_COSINE   = 16'h0001;
  localparam logic [15:0] TRIG_MAX_BCD = 16'h0900;
  localparam logic [9:0]  RIGHT_ANGLE  = 10'h384;
  localparam logic [13:0] FRAC_MAX     = 14'h270F;
  localparam logic [15:0] BCD_MAX_BIN  = 16'h270F;

  // first table word fields
  localparam int HDR_IN_BIN_BIT  = 15;
  localparam int HDR_OUT_BIN_BIT = 14;
  localparam int HDR_MIRROR_BIT  = 13;
  localparam int HDR_SEGS_LSB    = 0;

  // fixed point Q30 constants for the sine series, plus decimal scale and last divider step index
  localparam logic [31:0] TENTH_DEG_RAD = 32'h001C_9871;
  localparam logic [31:0] Q_ONE         = 32'h4000_0000;
  localparam logic [31:0] Q_C3          = 32'h0AAA_AAAB;
  localparam logic [31:0] Q_C5          = 32'h0088_8889;
  localparam logic [31:0] Q_C7          = 32'h0003_4034;
  localparam logic [31:0] Q_C9          = 32'h0000_0B8F;
  localparam logic [31:0] Q_BIAS        = 32'h0000_00C8;
  localparam logic [31:0] DEC_SCALE     = 32'h0000_2710;
  localparam logic [5:0]  DIV_STEPS     = 6'h1F;

  typedef enum logic [11:0] {
    TPL_IDLE = 12'h001,
    TPL_SRC  = 12'h002,
    TPL_TRIG = 12'h004,
    TPL_HDR  = 12'h008,
    TPL_XM   = 12'h010,
    TPL_Y0   = 12'h020,
    TPL_X    = 12'h040,
    TPL_Y    = 12'h080,
    TPL_DIV  = 12'h100,
    TPL_OUT  = 12'h200,
    TPL_WR   = 12'h400,
    TPL_SPR  = 12'h800
  } tpl_state_e;

endpackage : tpl_pkg

// *** hdl/tpl_sine.sv ***
`timescale 1ns/100ps
`default_nettype none
module tpl_sine
  import tpl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic        cos_sel,
  input  wire logic [9:0]  angle,
  output logic             done,
  output logic [13:0]      value
);

  logic [2:0]  step;
  logic [31:0] x;
  logic [31:0] s;
  logic [31:0] p;
  logic [31:0] y;

  // cosine is the sine of the complement
  wire [9:0]  ang  = cos_sel ? RIGHT_ANGLE - angle : angle;
  wire [63:0] prod_ang = {54'h0, ang} * {32'h0, TENTH_DEG_RAD};
  wire [63:0] prod_xx  = {32'h0, x} * {32'h0, x};
  wire [63:0] prod_sp  = {32'h0, s} * {32'h0, p};
  wire [63:0] prod_xp  = {32'h0, x} * {32'h0, p};
  wire [63:0] prod_dec = {32'h0, y} * {32'h0, DEC_SCALE};
  // truncated digits, exact one clamps to 0.9999
  wire [13:0] dec  = prod_dec[43:30];
  wire [31:0] coef = step == 3'h2 ? Q_C7 :
                     step == 3'h3 ? Q_C5 :
                     step == 3'h4 ? Q_C3 : Q_ONE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step  <= 3'h0;
      x     <= 32'h0;
      s     <= 32'h0;
      p     <= 32'h0;
      y     <= 32'h0;
      done  <= 1'b0;
      value <= 14'h0;
    end else begin
      done <= 1'b0;
      case (step)
        3'h0: begin
          if (start) begin
            x    <= prod_ang[31:0];
            step <= 3'h1;
          end
        end
        3'h1: begin
          s    <= prod_xx[61:30];
          p    <= Q_C9;
          step <= 3'h2;
        end
        3'h6: begin
          y    <= prod_xp[61:30] + Q_BIAS;
          step <= 3'h7;
        end
        3'h7: begin
          value <= dec > FRAC_MAX ? FRAC_MAX : dec;
          done  <= 1'b1;
          step  <= 3'h0;
        end
        default: begin
          p    <= coef - prod_sp[61:30];
          step <= step + 3'h1;
        end
      endcase
    end
  end

endmodule : tpl_sine
`default_nettype wire

// *** hdl/tpl_eval.sv ***
// Behaviour
// - selector zero computes sine
// - selector one computes cosine
// - four BCD fraction digits, truncated
// - exact one is written as 0.9999
// - address selector runs table curve evaluation
// - table low byte holds segments minus one
// - bit 15 input, bit 14 output format
// - bit 13 mirrors curve left to right
// - no action while execution condition false
// - trig angle in tenths of degree
// - error on bad selector, angle, table
`timescale 1ns/100ps
`default_nettype none
module tpl_eval
  import tpl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             mem_req,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic        mem_err
);

  function automatic logic bcd_ok(input logic [15:0] v);
    bcd_ok = v[15:12] < 4'hA && v[11:8] < 4'hA &&
             v[7:4] < 4'hA && v[3:0] < 4'hA;
  endfunction : bcd_ok

  function automatic logic [15:0] bcd2bin(input logic [15:0] v);
    logic [15:0] r;
    r = 16'(v[15:12]) * 16'd1000 + 16'(v[11:8]) * 16'd100 +
        16'(v[7:4]) * 16'd10 + 16'(v[3:0]);
    bcd2bin = r;
  endfunction : bcd2bin

  function automatic logic [15:0] bin2bcd(input logic [15:0] b);
    logic [31:0] sh;
    sh = {16'h0, b};
    for (int i = 0; i < 16; i++) begin
      for (int d = 0; d < 4; d++) begin
        if (sh[16 + 4*d +: 4] > 4'h4) begin
          sh[16 + 4*d +: 4] = sh[16 + 4*d +: 4] + 4'h3;
        end
      end
      sh = {sh[30:0], 1'b0};
    end
    bin2bcd = sh[31:16];
  endfunction : bin2bcd

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = a == ADDR_CTRL || a == ADDR_SEL || a == ADDR_SRC ||
              a == ADDR_DST || a == ADDR_STATUS ||
              a == ADDR_RESULT || a == ADDR_INT_STAT ||
              a == ADDR_INT_MASK;
  endfunction : reg_hit

  tpl_state_e  state;
  logic [1:0]  ctrl;
  logic [15:0] sel;
  logic [15:0] src_addr;
  logic [15:0] dst_addr;
  logic [15:0] result;
  logic        err_f;
  logic        zero_f;
  logic [1:0]  int_stat;
  logic [1:0]  int_mask;
  logic [1:0]  ev;
  logic [15:0] maddr;
  logic [15:0] src;
  logic [15:0] hdr;
  logic [15:0] x;
  logic [15:0] xp;
  logic [15:0] yp;
  logic [15:0] xc;
  logic [7:0]  idx;
  logic [15:0] res_bin;
  logic [15:0] wdata;
  logic        is_pwl;
  logic        trig_go;
  logic        neg;
  logic [5:0]  div_cnt;
  logic [32:0] rem;
  logic [31:0] quo;
  logic [15:0] den;
  logic        trig_done;
  logic [13:0] trig_val;

  // register bus decode
  wire setup    = psel & ~penable;
  wire access   = psel & penable;
  wire hit      = reg_hit(paddr);
  wire wr_acc   = access & pwrite & hit;
  wire wr_ctrl  = wr_acc & paddr == ADDR_CTRL;
  wire wr_sel   = wr_acc & paddr == ADDR_SEL;
  wire wr_src   = wr_acc & paddr == ADDR_SRC;
  wire wr_dst   = wr_acc & paddr == ADDR_DST;
  wire wr_istat = wr_acc & paddr == ADDR_INT_STAT;
  wire wr_imask = wr_acc & paddr == ADDR_INT_MASK;
  wire idle     = state == TPL_IDLE;
  // a run only starts with the execution condition true
  wire run      = wr_ctrl & pwdata[CTRL_RUN_BIT] &
                  pwdata[CTRL_EXEC_BIT] & idle;
  wire [2:0] status = {zero_f, err_f, ~idle};
  wire [31:0] rd_mux =
    paddr == ADDR_CTRL     ? {30'h0, ctrl} :
    paddr == ADDR_SEL      ? {16'h0, sel} :
    paddr == ADDR_SRC      ? {16'h0, src_addr} :
    paddr == ADDR_DST      ? {16'h0, dst_addr} :
    paddr == ADDR_STATUS   ? {29'h0, status} :
    paddr == ADDR_RESULT   ? {16'h0, result} :
    paddr == ADDR_INT_STAT ? {30'h0, int_stat} :
    paddr == ADDR_INT_MASK ? {30'h0, int_mask} : 32'h0;
  wire [1:0] istat_clr = wr_istat ? pwdata[1:0] : 2'h0;

  assign pready  = 1'b1;
  assign pslverr = access & ~hit;
  assign irq     = |(int_stat & int_mask);

  // memory port
  assign mem_req   = ~(idle | state == TPL_TRIG | state == TPL_DIV |
                       state == TPL_OUT | state == TPL_SPR);
  assign mem_we    = state == TPL_WR;
  assign mem_addr  = maddr;
  assign mem_wdata = wdata;
  wire   got       = mem_req & mem_ack & ~mem_err;
  wire   bad_rd    = mem_req & mem_ack & mem_err;

  // table and source decoding
  wire        in_bin   = hdr[HDR_IN_BIN_BIT];
  wire [15:0] x_raw    = in_bin ? src : bcd2bin(src);
  wire        x_bad    = ~in_bin & ~bcd_ok(src);
  wire [15:0] x_clamp  = x_raw > mem_rdata ? mem_rdata : x_raw;
  wire [15:0] x_eff    = hdr[HDR_MIRROR_BIT] ?
                         mem_rdata - x_clamp : x_clamp;
  // last word is C+2m+2, with m one above the stored count
  wire [16:0] tbl_end  = {1'b0, maddr} +
                         {8'h0, mem_rdata[7:0], 1'b0} + 17'h4;
  wire        tbl_bad  = tbl_end[16];
  wire        last_seg = idx - 8'h1 == hdr[7:0];
  wire        trig_bad = ~bcd_ok(mem_rdata) ||
                         mem_rdata > TRIG_MAX_BCD;
  wire        sel_bad  = sel != SEL_SINE && sel != SEL_COSINE;
  wire [15:0] dy       = mem_rdata >= yp ? mem_rdata - yp :
                         yp - mem_rdata;
  wire [31:0] num      = {16'h0, dy} * {16'h0, x - xp};
  wire [32:0] rem_sh   = {rem[31:0], quo[31]};
  wire        sub_ok   = rem_sh >= {17'h0, den};
  wire [15:0] y_div    = neg ? yp - quo[15:0] : yp + quo[15:0];
  wire        out_bin  = is_pwl & hdr[HDR_OUT_BIN_BIT];
  wire [15:0] trig_bin = bcd2bin(src);

  tpl_sine u_sine (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (trig_go),
    .cos_sel (sel[0]),
    .angle   (trig_bin[9:0]),
    .done    (trig_done),
    .value   (trig_val)
  );

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= CTRL_RESET;
      sel      <= 16'h0000;
      src_addr <= 16'h0000;
      dst_addr <= 16'h0000;
      int_mask <= INT_RESET;
    end else begin
      if (wr_ctrl) ctrl <= pwdata[1:0];
      if (wr_sel) sel <= pwdata[15:0];
      if (wr_src) src_addr <= pwdata[15:0];
      if (wr_dst) dst_addr <= pwdata[15:0];
      if (wr_imask) int_mask <= pwdata[1:0];
    end
  end

  // read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (setup) prdata <= rd_mux;
  end

  // sticky events, a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) int_stat <= INT_RESET;
    else int_stat <= (int_stat & ~istat_clr) | ev;
  end

  // evaluation sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= TPL_IDLE;
      maddr   <= 16'h0;
      src     <= 16'h0;
      hdr     <= 16'h0;
      x       <= 16'h0;
      xp      <= 16'h0;
      yp      <= 16'h0;
      xc      <= 16'h0;
      idx     <= 8'h0;
      res_bin <= 16'h0;
      wdata   <= 16'h0;
      result  <= 16'h0;
      err_f   <= 1'b0;
      zero_f  <= 1'b0;
      is_pwl  <= 1'b0;
      trig_go <= 1'b0;
      neg     <= 1'b0;
      div_cnt <= 6'h0;
      rem     <= 33'h0;
      quo     <= 32'h0;
      den     <= 16'h0;
      ev      <= 2'h0;
    end else begin
      ev      <= 2'h0;
      trig_go <= 1'b0;
      if (bad_rd) begin
        err_f  <= 1'b1;
        ev     <= 2'h2;
        state  <= TPL_IDLE;
      end else begin
        case (state)
          TPL_IDLE: begin
            if (run) begin
              err_f  <= 1'b0;
              zero_f <= 1'b0;
              is_pwl <= pwdata[CTRL_ADDR_BIT];
              maddr  <= src_addr;
              state  <= TPL_SRC;
            end
          end
          TPL_SRC: begin
            if (got) begin
              src <= mem_rdata;
              if (is_pwl) begin
                maddr <= sel;
                state <= TPL_HDR;
              end else if (sel_bad || trig_bad) begin
                err_f <= 1'b1;
                ev    <= 2'h2;
                state <= TPL_IDLE;
              end else begin
                trig_go <= 1'b1;
                state   <= TPL_TRIG;
              end
            end
          end
          TPL_TRIG: begin
            if (trig_done) begin
              res_bin <= {2'h0, trig_val};
              state   <= TPL_OUT;
            end
          end
          TPL_HDR: begin
            if (got) begin
              hdr <= mem_rdata;
              if (tbl_bad) begin
                err_f <= 1'b1;
                ev    <= 2'h2;
                state <= TPL_IDLE;
              end else begin
                maddr <= maddr + 16'h1;
                state <= TPL_XM;
              end
            end
          end
          TPL_XM: begin
            if (got) begin
              if (x_bad) begin
                err_f <= 1'b1;
                ev    <= 2'h2;
                state <= TPL_IDLE;
              end else begin
                x     <= x_eff;
                maddr <= maddr + 16'h1;
                state <= TPL_Y0;
              end
            end
          end
          TPL_Y0: begin
            if (got) begin
              yp    <= mem_rdata;
              xp    <= 16'h0;
              idx   <= 8'h1;
              maddr <= maddr + 16'h1;
              state <= TPL_X;
            end
          end
          TPL_X: begin
            if (got) begin
              xc    <= mem_rdata;
              maddr <= maddr + 16'h1;
              state <= TPL_Y;
            end
          end
          TPL_Y: begin
            if (got) begin
              if (x == xc || (x > xc && last_seg)) begin
                res_bin <= mem_rdata;
                state   <= TPL_OUT;
              end else if (x < xc) begin
                neg     <= mem_rdata < yp;
                den     <= xc - xp;
                rem     <= 33'h0;
                quo     <= num;
                div_cnt <= 6'h0;
                state   <= TPL_DIV;
              end else begin
                xp    <= xc;
                yp    <= mem_rdata;
                idx   <= idx + 8'h1;
                maddr <= maddr + 16'h1;
                state <= TPL_X;
              end
            end
          end
          TPL_DIV: begin
            rem <= sub_ok ? rem_sh - {17'h0, den} : rem_sh;
            quo <= {quo[30:0], sub_ok};
            div_cnt <= div_cnt + 6'h1;
            if (div_cnt == DIV_STEPS) state <= TPL_SPR;
          end
          TPL_SPR: begin
            res_bin <= y_div;
            state   <= TPL_OUT;
          end
          TPL_OUT: begin
            maddr <= dst_addr;
            if (out_bin) begin
              wdata <= res_bin;
              state <= TPL_WR;
            end else if (res_bin > BCD_MAX_BIN) begin
              err_f <= 1'b1;
              ev    <= 2'h2;
              state <= TPL_IDLE;
            end else begin
              wdata <= bin2bcd(res_bin);
              state <= TPL_WR;
            end
          end
          TPL_WR: begin
            if (got) begin
              result <= wdata;
              zero_f <= wdata == 16'h0;
              ev     <= 2'h1;
              state  <= TPL_IDLE;
            end
          end
          default: state <= TPL_IDLE;
        endcase
      end
    end
  end

endmodule : tpl_eval
`default_nettype wire

// *** testbench/tpl_eval_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module tpl_eval_checker
  import tpl_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic        mem_ack,
  input wire logic        mem_err
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc     = psel && penable;
  wire unmap   = (paddr > ADDR_INT_MASK) || (paddr[1:0] != 2'h0);
  wire ctrl_wr = acc && pwrite && (paddr == ADDR_CTRL);
  property p_ready_high; pready; endproperty
  a_ready_high: assert property (p_ready_high) else $error("pready low");
  property p_slverr_bad; acc && unmap |-> pslverr && prdata == 32'h0;
  endproperty
  a_slverr_bad: assert property (p_slverr_bad) else $error("no slverr");
  property p_slverr_ok; acc && !unmap |-> !pslverr; endproperty
  a_slverr_ok: assert property (p_slverr_ok) else $error("stray slverr");
  property p_req_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
      && $stable(mem_wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped");
  property p_we_req; mem_we |-> mem_req; endproperty
  a_we_req: assert property (p_we_req) else $error("we without req");
  property p_run_starts;
    ctrl_wr && pwdata[0] && pwdata[2] && !mem_req |=> ##[0:1] mem_req && !mem_we;
  endproperty
  a_run_starts: assert property (p_run_starts) else $error("no src read");
  property p_no_exec; ctrl_wr && !pwdata[0] && !mem_req |=> !mem_req [*3];
  endproperty
  a_no_exec: assert property (p_no_exec) else $error("run without exec");
  property p_write_ends; mem_req && mem_we && mem_ack |=> !mem_req;
  endproperty
  a_write_ends: assert property (p_write_ends) else $error("req after write");
  property p_mask_zero;
    acc && pwrite && paddr == ADDR_INT_MASK && pwdata[1:0] == 2'h0 |=> !irq;
  endproperty
  a_mask_zero: assert property (p_mask_zero) else $error("irq while masked");
  c_run: cover property (ctrl_wr && pwdata[2]);
  c_wr: cover property (mem_req && mem_we && mem_ack);
  c_err: cover property (mem_ack && mem_err);
  c_irq: cover property (irq);
endmodule : tpl_eval_checker
`default_nettype wire

// *** testbench/tpl_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module tpl_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  lat,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic [15:0]      mem_rdata,
  output logic             mem_ack,
  output logic             mem_err
);
  logic [15:0] mem [0:255];
  logic [3:0]  wait_cnt;
  // page E (address top nibble 4'hE) is absent storage
  wire         bad = (mem_addr[15:12] == 4'hE);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
      mem_rdata <= 16'h0000;
      wait_cnt  <= 4'h0;
    end else begin
      if (mem_ack && mem_req && mem_we && !mem_err)
        mem[mem_addr[7:0]] <= mem_wdata;
      if (mem_req && !mem_ack && wait_cnt >= lat) begin
        mem_ack   <= 1'b1;
        mem_err   <= bad;
        wait_cnt  <= 4'h0;
        mem_rdata <= (mem_we || bad) ? ~mem_rdata : mem[mem_addr[7:0]];
      end else begin
        // released bus never keeps the last word
        mem_ack   <= 1'b0;
        mem_err   <= 1'b0;
        mem_rdata <= ~mem_rdata;
        wait_cnt  <= (mem_req && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
      end
    end
  end
endmodule : tpl_mem_model
`default_nettype wire

// *** testbench/tpl_eval_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tpl_eval_tb_top
  import tpl_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, irq, sl, mem_req, mem_we, mem_ack, mem_err;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [3:0]  lat = 0;
  int          err_total = 0, checks_done = 0;
  always #2.5 pclk = ~pclk;
  tpl_eval i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .mem_err(mem_err));
  tpl_mem_model i_mem (.pclk(pclk), .presetn(presetn), .lat(lat),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .mem_err(mem_err));
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    sl = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // one run: selector, header, source word; dest preset to a marker
  task automatic t(input logic [15:0] sel, input logic adr,
                   input logic [15:0] hdr, input logic [15:0] src,
                   input logic [15:0] exp, input logic [1:0] fl);
    i_mem.mem[8'h10] = hdr;
    i_mem.mem[8'h40] = src;
    i_mem.mem[8'h41] = 16'hDEAD;
    lat <= lat + 4'h1;
    apb(1'b1, ADDR_SEL, {16'h0, sel});
    apb(1'b1, ADDR_CTRL, {29'h0, 1'b1, adr, 1'b1});
    do apb(1'b0, ADDR_STATUS, 32'h0); while (rd[0] !== 1'b0);
    chk({30'h0, rd[2:1]}, {30'h0, fl});
    chk({16'h0, i_mem.mem[8'h41]}, {16'h0, exp});
    if (!fl[0]) begin
      apb(1'b0, ADDR_RESULT, 32'h0);
      chk(rd, {16'h0, exp});
    end
    $display("test sel %h hdr %h src %h done", sel, hdr, src);
  endtask : t
  initial begin
    repeat (40000) @(posedge pclk);
    err_total++;
    final_report();
  end
  initial begin
    logic [7:0] ra [4];
    logic [15:0] tbl [6];
    ra = '{ADDR_STATUS, ADDR_RESULT, ADDR_INT_STAT, ADDR_INT_MASK};
    // Xm, Y0, X1, Y1, X2, Y2 in binary, X ascending
    tbl = '{16'h0020, 16'h0000, 16'h0010, 16'h0100, 16'h0020, 16'h0080};
    foreach (tbl[i]) i_mem.mem[8'h11 + i] = tbl[i];
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({sl, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, ADDR_SRC, 32'h40);
    apb(1'b1, ADDR_DST, 32'h41);
    $display("register tests done");
    t(SEL_SINE, 1'b0, 16'h0, 16'h0300, 16'h5000, 2'b00);
    t(SEL_COSINE, 1'b0, 16'h0, 16'h0300, 16'h8660, 2'b00);
    t(SEL_SINE, 1'b0, 16'h0, 16'h0900, 16'h9999, 2'b00);
    t(SEL_COSINE, 1'b0, 16'h0, 16'h0000, 16'h9999, 2'b00);
    t(SEL_SINE, 1'b0, 16'h0, 16'h0000, 16'h0000, 2'b10);
    t(SEL_SINE, 1'b0, 16'h0, 16'h0901, 16'hDEAD, 2'b01);
    t(16'h0002, 1'b0, 16'h0, 16'h0300, 16'hDEAD, 2'b01);
    t(16'h0010, 1'b1, 16'hC001, 16'h0008, 16'h0080, 2'b00);
    t(16'h0010, 1'b1, 16'hC001, 16'h0010, 16'h0100, 2'b00);
    t(16'h0010, 1'b1, 16'hC001, 16'h0018, 16'h00C0, 2'b00);
    t(16'h0010, 1'b1, 16'hE001, 16'h0018, 16'h0080, 2'b00);
    t(16'h0010, 1'b1, 16'h0001, 16'h0008, 16'h0128, 2'b00);
    t(16'h0010, 1'b1, 16'h8001, 16'h0008, 16'h0128, 2'b00);
    t(16'h0010, 1'b1, 16'h4001, 16'h0008, 16'h0080, 2'b00);
    t(16'h0010, 1'b1, 16'h0001, 16'h000A, 16'hDEAD, 2'b01);
    t(16'hE000, 1'b1, 16'h0001, 16'h0008, 16'hDEAD, 2'b01);
    i_mem.mem[8'h41] = 16'hDEAD;
    apb(1'b1, ADDR_CTRL, 32'h4);
    repeat (20) @(posedge pclk);
    chk({16'h0, i_mem.mem[8'h41]}, 32'hDEAD);
    $display("execution condition test done");
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, ADDR_INT_MASK, 32'h1);
    #1 chk({31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_INT_STAT, 32'h1);
    #1 chk({31'h0, irq}, 32'h0);
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, ADDR_INT_MASK, 32'h2);
    #1 chk({31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_INT_MASK, 32'h0);
    #1 chk({31'h0, irq}, 32'h0);
    $display("interrupt test done");
    final_report();
  end
endmodule : tpl_eval_tb_top
bind tpl_eval tpl_eval_checker i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
  .mem_err(mem_err));
`default_nettype wire
